// *** rtl/ccps_defines.svh ***
// Offsets, field positions, reset values and codes for the CC and power status registers
`ifndef CCPS_DEFINES_SVH
`define CCPS_DEFINES_SVH
`define CCPS_CC_STATUS_ADDR 8'h1D
`define CCPS_PWR_STATUS_ADDR 8'h1E
`define CCPS_CC_STATUS_RST 8'h00
`define CCPS_PWR_STATUS_RST 8'h08
`define CCPS_CC_SEARCH_BIT 5
`define CCPS_CC_ROLE_BIT 4
`define CCPS_PWR_DBG_BIT 7
`define CCPS_PWR_INIT_BIT 6
`define CCPS_PWR_HV_BIT 5
`define CCPS_PWR_SRC_BIT 4
`define CCPS_PWR_DETEN_BIT 3
`define CCPS_PWR_VBUS_BIT 2
`define CCPS_PWR_VCONN_BIT 1
`define CCPS_PWR_SNK_BIT 0
`define CCPS_TERM_RA 2'h0
`define CCPS_TERM_RP 2'h1
`define CCPS_TERM_RD 2'h2
`define CCPS_TERM_OPEN 2'h3
`define CCPS_CODE_OPEN 2'h0
`endif

// *** rtl/ccps_pkg.sv ***
// Types shared by the CC and power status register bank
package ccps_pkg;
  // Per-line termination setting
  typedef logic [1:0] ccps_term_t;
  // Per-line status code
  typedef logic [1:0] ccps_code_t;
endpackage

// *** rtl/ccps_status_regs.sv ***
// CC line status and power status registers with change alerts
//
// Overview of operation
// - bit5 high while searching for connection
// - bit4 zero for Rp, one for Rd
// - Rp side codes open, Ra, Rd
// - Rd side codes open, default, 1.5A, 3A
// - Ra or open termination reports 00b
// - Fields zero while searching or VCONN flip-zero
// - Bits 7:6 always read zero
// - CC status change raises its alert
// - Power bit7 mirrors debug accessory output
// - Power bit6 high during initialization
// - Power bit5 high when sourcing high voltage
// - Power bit4 is source output and enable
// - Power bit3 shows detection circuit enabled
// - Power bit2 VBUS present with hysteresis
// - Power bit1 VCONN present and enabled
// - Power bit0 mirrors sink enable output
// - Power status resets to 08h
// - Power status change raises its alert
// - CC status at 1Dh, read-only, resets zero
// - Termination codes Ra, Rp, Rd, open
// - Flip bit zero routes VCONN to line two
`timescale 1ns/1ps
`default_nettype none
`include "ccps_defines.svh"

module ccps_status_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register read port
  input wire logic [7:0] reg_addr_i,
  output logic [7:0] reg_rdata_o,
  // Configuration from the control registers
  input wire ccps_pkg::ccps_term_t line_one_termination_i,
  input wire ccps_pkg::ccps_term_t line_two_termination_i,
  input wire logic cable_power_enable_i,
  input wire logic flip_bit_i,
  // Connection detection state
  input wire logic searching_connection_i,
  input wire logic resolved_role_i,
  input wire ccps_pkg::ccps_code_t line_one_sense_i,
  input wire ccps_pkg::ccps_code_t line_two_sense_i,
  // Power path state
  input wire logic dbg_accessory_attached_i,
  input wire logic init_in_progress_i,
  input wire logic supplying_high_voltage_i,
  input wire logic source_output_on_i,
  input wire logic source_bus_enabled_i,
  input wire logic bus_present_detect_on_i,
  input wire logic bus_above_rise_i,
  input wire logic bus_below_fall_i,
  input wire logic cable_above_threshold_i,
  input wire logic consume_output_on_i,
  // Status outputs and alerts
  output logic [7:0] cc_line_status_o,
  output logic [7:0] power_status_o,
  output logic line_status_alert_o,
  output logic power_status_alert_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Line status codes

  ccps_pkg::ccps_term_t term_w [2]; // Per-line termination
  ccps_pkg::ccps_code_t sense_w [2]; // Per-line sensed code
  ccps_pkg::ccps_code_t code_w [2]; // Per-line reported code
  logic blank_w; // Forces both codes to open
  logic [7:0] cc_d; // Next CC status value
  logic [7:0] cc_line_status_q; // Latched CC status
  logic [7:0] pwr_d; // Next power status value
  logic [7:0] power_status_q; // Latched power status
  logic bus_present_q; // Hysteretic VBUS present

  assign term_w[0] = line_one_termination_i;
  assign term_w[1] = line_two_termination_i;
  assign sense_w[0] = line_one_sense_i;
  assign sense_w[1] = line_two_sense_i;

  // Searching, or VCONN sent to line two with line one monitored
  assign blank_w = searching_connection_i
                 | (cable_power_enable_i & ~flip_bit_i);

  // One code per line; Ra and open termination report open
  generate
    for (genvar i = 0; i < 2; i++) begin : g_line
      always_comb begin
        if (blank_w) begin
          code_w[i] = `CCPS_CODE_OPEN;
        end else if (term_w[i] == `CCPS_TERM_RA || term_w[i] == `CCPS_TERM_OPEN) begin
          code_w[i] = `CCPS_CODE_OPEN;
        end else if (term_w[i] == `CCPS_TERM_RP && sense_w[i] == 2'h3) begin
          code_w[i] = `CCPS_CODE_OPEN; // Reserved source code suppressed
        end else begin
          code_w[i] = sense_w[i];
        end
      end
    end
  endgenerate

  // Assemble the CC status value
  always_comb begin
    cc_d = 8'h00; // Reserved bits stay zero
    cc_d[`CCPS_CC_SEARCH_BIT] = searching_connection_i;
    cc_d[`CCPS_CC_ROLE_BIT] = resolved_role_i;
    cc_d[3:2] = code_w[1];
    cc_d[1:0] = code_w[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power status

  // VBUS present flag holds between the two thresholds
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bus_present_q <= 1'b0;
    end else if (!bus_present_detect_on_i) begin
      bus_present_q <= 1'b0;
    end else if (bus_above_rise_i) begin
      bus_present_q <= 1'b1;
    end else if (bus_below_fall_i) begin
      bus_present_q <= 1'b0;
    end
  end

  // Assemble the power status value
  always_comb begin
    pwr_d = 8'h00;
    pwr_d[`CCPS_PWR_DBG_BIT] = dbg_accessory_attached_i;
    pwr_d[`CCPS_PWR_INIT_BIT] = init_in_progress_i;
    pwr_d[`CCPS_PWR_HV_BIT] = supplying_high_voltage_i;
    pwr_d[`CCPS_PWR_SRC_BIT] = source_output_on_i & source_bus_enabled_i;
    pwr_d[`CCPS_PWR_DETEN_BIT] = bus_present_detect_on_i;
    pwr_d[`CCPS_PWR_VBUS_BIT] = bus_present_q;
    pwr_d[`CCPS_PWR_VCONN_BIT] = cable_above_threshold_i & cable_power_enable_i;
    pwr_d[`CCPS_PWR_SNK_BIT] = consume_output_on_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status latches and change alerts

  // CC status latch
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cc_line_status_q <= `CCPS_CC_STATUS_RST;
    end else begin
      cc_line_status_q <= cc_d;
    end
  end

  // Power status latch
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      power_status_q <= `CCPS_PWR_STATUS_RST;
    end else begin
      power_status_q <= pwr_d;
    end
  end

  // Alert pulses when the new value differs from the latched one
  assign line_status_alert_o = ~sys_rst_i & (cc_d != cc_line_status_q);
  assign power_status_alert_o = ~sys_rst_i & (pwr_d != power_status_q);

  assign cc_line_status_o = cc_line_status_q;
  assign power_status_o = power_status_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Read-only decode; other addresses read zero
  always_comb begin
    case (reg_addr_i)
      `CCPS_CC_STATUS_ADDR: reg_rdata_o = cc_line_status_q;
      `CCPS_PWR_STATUS_ADDR: reg_rdata_o = power_status_q;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Connection search is active in this cycle
  sequence s_search_on;
    searching_connection_i;
  endsequence

  // Line one codes are live and it terminates with Rp
  sequence s_line_one_rp;
    !blank_w && line_one_termination_i == `CCPS_TERM_RP;
  endsequence

  // Line one codes are live and it terminates with Rd
  sequence s_line_one_rd;
    !blank_w && line_one_termination_i == `CCPS_TERM_RD;
  endsequence

  // VCONN sent to line one, line two terminates with Rd
  sequence s_line_two_flipped;
    cable_power_enable_i && flip_bit_i && !searching_connection_i
      && line_two_termination_i == `CCPS_TERM_RD;
  endsequence

  // Detector on and bus above the upper threshold
  sequence s_bus_rise;
    bus_present_detect_on_i && bus_above_rise_i;
  endsequence

  // Detector off, or bus below the lower threshold
  sequence s_bus_drop;
    !bus_present_detect_on_i || (bus_below_fall_i && !bus_above_rise_i);
  endsequence

  // CC status register contents
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cc_line_status_o[7:6] == 2'h0) else $error("CC reserved bits nonzero");
  chk_search_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_search_on |=> cc_line_status_o[5] && cc_line_status_o[3:0] == 4'h0)
    else $error("Search bit or blanking wrong");
  chk_role_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> cc_line_status_o[4] == $past(resolved_role_i))
    else $error("Role bit wrong");
  chk_ra_open: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    line_one_termination_i == `CCPS_TERM_RA || line_one_termination_i == `CCPS_TERM_OPEN
    |=> cc_line_status_o[1:0] == 2'h0)
    else $error("Line one code nonzero");
  chk_line_two_open: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    line_two_termination_i == `CCPS_TERM_RA || line_two_termination_i == `CCPS_TERM_OPEN
    |=> cc_line_status_o[3:2] == 2'h0)
    else $error("Line two code nonzero");
  chk_rp_codes: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_line_one_rp |=> cc_line_status_o[1:0] == (($past(line_one_sense_i) == 2'h3) ? 2'h0
      : $past(line_one_sense_i)))
    else $error("Source side code wrong");
  chk_rd_codes: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_line_one_rd |=> cc_line_status_o[1:0] == $past(line_one_sense_i))
    else $error("Sink side code wrong");
  chk_flip_unblank: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_line_two_flipped |=> cc_line_status_o[3:2] == $past(line_two_sense_i))
    else $error("Flipped line two code wrong");
  chk_vconn_blank: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cable_power_enable_i && !flip_bit_i |=> cc_line_status_o[3:0] == 4'h0)
    else $error("VCONN blanking failed");

  // CC change alert and reset value
  chk_cc_change: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(cc_line_status_o) && !$past(sys_rst_i) |-> $past(line_status_alert_o))
    else $error("CC change without alert");
  chk_cc_alert: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    line_status_alert_o |=> cc_line_status_o != $past(cc_line_status_o))
    else $error("CC alert without change");
  chk_cc_reset: assert property (@(posedge mclk_i)
    sys_rst_i |=> cc_line_status_o == 8'h00) else $error("CC reset value wrong");

  // Read port returns the addressed register, zero elsewhere
  chk_read_decode: assert property (@(posedge mclk_i)
    reg_rdata_o == ((reg_addr_i == `CCPS_CC_STATUS_ADDR) ? cc_line_status_o
      : (reg_addr_i == `CCPS_PWR_STATUS_ADDR) ? power_status_o : 8'h00))
    else $error("Read data wrong");

  // Power status bits that mirror their inputs one edge later
  chk_dbg_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[7] == $past(dbg_accessory_attached_i))
    else $error("Debug accessory bit wrong");
  chk_init_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[6] == $past(init_in_progress_i))
    else $error("Initialization bit wrong");
  chk_hv_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[5] == $past(supplying_high_voltage_i))
    else $error("High voltage bit wrong");
  chk_src_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[4]
      == ($past(source_output_on_i) & $past(source_bus_enabled_i)))
    else $error("Source bit wrong");
  chk_deten_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[3] == $past(bus_present_detect_on_i))
    else $error("Detect enable bit wrong");
  chk_vconn_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[1]
      == ($past(cable_above_threshold_i) & $past(cable_power_enable_i)))
    else $error("VCONN present bit wrong");
  chk_sink_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !sys_rst_i |=> power_status_o[0] == $past(consume_output_on_i))
    else $error("Sink bit wrong");

  // Hysteretic VBUS present bit, two edges behind its comparators
  chk_vbus_hyst: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_bus_rise |=> ##1 power_status_o[2])
    else $error("VBUS present not set");
  chk_vbus_drop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_bus_drop |=> ##1 !power_status_o[2])
    else $error("VBUS present not cleared");

  // Power change alert and reset value
  chk_pwr_alert: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $changed(power_status_o) && !$past(sys_rst_i) |-> $past(power_status_alert_o))
    else $error("Power change without alert");
  chk_pwr_step: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    power_status_alert_o |=> power_status_o != $past(power_status_o))
    else $error("Power alert without change");
  chk_pwr_reset: assert property (@(posedge mclk_i)
    sys_rst_i |=> power_status_o == 8'h08) else $error("Power reset value wrong");

endmodule // ccps_status_regs
`default_nettype wire

// *** verification/ccps_cable_model.sv ***
// Cable partner model: turns bus and cable voltages into comparator levels
`timescale 1ns/1ps
`default_nettype none
module ccps_cable_model #(
  parameter int RISE_MV = 4000,
  parameter int FALL_MV = 3500,
  parameter int CABLE_MV = 2400
) (
  // Voltages in millivolts
  input wire logic [15:0] bus_mv_i,
  input wire logic [15:0] cable_mv_i,
  // Comparator levels
  output logic bus_above_rise_o,
  output logic bus_below_fall_o,
  output logic cable_above_o
);
  // Bus comparators, the gap between them gives hysteresis
  assign bus_above_rise_o = (int'(bus_mv_i) > RISE_MV);
  assign bus_below_fall_o = (int'(bus_mv_i) < FALL_MV);
  // Fixed cable power threshold
  assign cable_above_o = (int'(cable_mv_i) > CABLE_MV);
endmodule // ccps_cable_model
`default_nettype wire

// *** verification/ccps_status_regs_bench.sv ***
// Self-checking bench for the CC and power status registers
`timescale 1ns/1ps
`default_nettype none
module ccps_status_regs_bench;
  // Clock, reset, read port and outputs
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] rdata, cc_o, pw_o;
  logic al_cc, al_pw, rise, fall, cab;
  // Inputs driven by the bench
  logic [1:0] t1 = 2'h3, t2 = 2'h3, s1 = 2'h0, s2 = 2'h0;
  logic ven = 1'b0, flip = 1'b0, srch = 1'b0, role = 1'b0, dbg = 1'b0;
  logic init = 1'b0, hv = 1'b0, son = 1'b0, sen = 1'b0, den = 1'b1, snk = 1'b0;
  logic [15:0] bus_mv = 16'h0000, cab_mv = 16'h0BB8;
  int error_cnt = 0;
  int check_count = 0;
  // 40 MHz clock
  always #12.5 mclk_i = ~mclk_i;
  ccps_cable_model u_cable (.bus_mv_i(bus_mv), .cable_mv_i(cab_mv),
    .bus_above_rise_o(rise), .bus_below_fall_o(fall), .cable_above_o(cab));
  ccps_status_regs u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
    .reg_rdata_o(rdata), .line_one_termination_i(t1), .line_two_termination_i(t2),
    .cable_power_enable_i(ven), .flip_bit_i(flip), .searching_connection_i(srch),
    .resolved_role_i(role), .line_one_sense_i(s1), .line_two_sense_i(s2),
    .dbg_accessory_attached_i(dbg), .init_in_progress_i(init),
    .supplying_high_voltage_i(hv), .source_output_on_i(son), .source_bus_enabled_i(sen),
    .bus_present_detect_on_i(den), .bus_above_rise_i(rise), .bus_below_fall_i(fall),
    .cable_above_threshold_i(cab), .consume_output_on_i(snk), .cc_line_status_o(cc_o),
    .power_status_o(pw_o), .line_status_alert_o(al_cc), .power_status_alert_o(al_pw));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Read one address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    #1;
    chk(rdata, exp);
  endtask
  // Expected line code from termination and sensed code
  function automatic logic [1:0] ecode(input logic [1:0] t, input logic [1:0] s);
    if (t == 2'h1) return (s == 2'h3) ? 2'h0 : s;
    if (t == 2'h2) return s;
    return 2'h0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Every termination against every sensed code
  task automatic sc_codes();
    for (int t = 0; t < 4; t++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge mclk_i);
        t1 <= 2'(t);
        t2 <= 2'(t);
        s1 <= 2'(s);
        s2 <= 2'(3 - s);
        role <= (t == 2);
        tick(3);
        chk(cc_o, {3'h0, role, ecode(t2, s2), ecode(t1, s1)});
      end
    end
  endtask
  // Search, and cable power with flip clear, both force codes; setting flip restores them
  task automatic sc_mask();
    @(posedge mclk_i);
    {t1, t2, s1, s2, srch, role} <= {8'hA7, 2'h3};
    tick(3);
    rd(8'h1D, 8'h30);
    @(posedge mclk_i) {srch, ven} <= 2'h1;
    tick(3);
    rd(8'h1D, 8'h10);
    @(posedge mclk_i) flip <= 1'b1;
    tick(3);
    rd(8'h1D, 8'h1D);
    @(posedge mclk_i) {ven, flip} <= 2'h0;
  endtask
  // Power inputs {dbg,init,hv,son,sen,den,snk,ven,flip} and bus voltage
  task automatic pw(input logic [8:0] b, input logic [15:0] mv, input logic [7:0] exp);
    @(posedge mclk_i);
    {dbg, init, hv, son, sen, den, snk, ven, flip} <= b;
    bus_mv <= mv;
    tick(3);
    chk(pw_o, exp);
    rd(8'h1E, exp);
  endtask
  task automatic sc_power();
    pw(9'h108, 16'h0000, 8'h88);
    pw(9'h088, 16'h0000, 8'h48);
    pw(9'h048, 16'h0000, 8'h28);
    pw(9'h028, 16'h0000, 8'h08);
    pw(9'h038, 16'h0000, 8'h18);
    pw(9'h018, 16'h0000, 8'h08);
    pw(9'h00C, 16'h0000, 8'h09);
    pw(9'h00A, 16'h0000, 8'h0A);
    pw(9'h008, 16'h1194, 8'h0C);
    pw(9'h008, 16'h0ED8, 8'h0C);
    pw(9'h008, 16'h0BB8, 8'h08);
    pw(9'h008, 16'h0ED8, 8'h08);
    pw(9'h008, 16'h1194, 8'h0C);
    pw(9'h000, 16'h1194, 8'h00);
    pw(9'h008, 16'h0000, 8'h08);
  endtask
  // Each alert pulses once for its own register only
  task automatic sc_alert();
    @(posedge mclk_i);
    dbg <= 1'b1;
    #1;
    chk({6'h00, al_cc, al_pw}, 8'h01);
    tick(1);
    chk({6'h00, al_cc, al_pw}, 8'h00);
    @(posedge mclk_i) srch <= 1'b1;
    #1;
    chk({6'h00, al_cc, al_pw}, 8'h02);
    tick(1);
    chk({6'h00, al_cc, al_pw}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (50000) @(posedge mclk_i);
    error_cnt++;
    print_verdict();
  end
  // Main sequence, reads in reset then release
  initial begin
    repeat (12) @(posedge mclk_i);
    rd(8'h1D, 8'h00);
    rd(8'h1E, 8'h08);
    rd(8'h5A, 8'h00);
    @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    sc_codes();
    sc_mask();
    sc_power();
    sc_alert();
    print_verdict();
  end
endmodule // ccps_status_regs_bench
`default_nettype wire
